// ---- hdl/register_page_and_interface_config.sv ----
`timescale 1ns/100ps
`default_nettype none
module register_page_and_interface_config
#(
  parameter logic [3:0] DEFAULT_BASE_NIBBLE = 4'hD
)
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire regpage_pkg::access_req_t    req,
  input  wire logic                        access_end,
  input  wire logic [6:0]                  two_wire_addr,
  input  wire logic                        four_wire_dir_bit,
  input  wire logic                        setting_b_select_pin,
  input  wire logic                        emulated_read_active,
  input  wire logic                        fuse_reload_done,
  input  wire logic [7:0]                  fuse_interface_value,
  input  wire logic                        fuse_lock_value,
  output regpage_pkg::access_rsp_t         rsp,
  output logic                             two_wire_addr_match,
  output logic                             two_wire_addr_upper,
  output logic                             two_wire_addr_read,
  output logic                             four_wire_is_read,
  output logic [3:0]                       active_base_nibble,
  output regpage_pkg::buck_setting_t       active_setting,
  output logic [10:0]                      active_millivolts,
  output logic                             fuse_reload_start,
  output logic                             fuse_marginal_read,
  output logic                             app_settings_lock
);
  import regpage_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  logic sel_meta;
  logic sel_sync;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end
    else
    begin
      sel_meta <= setting_b_select_pin;
      sel_sync <= sel_meta;
    end
  end

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  buck_setting_t setting_a;
  buck_setting_t setting_b;
  logic [7:0]    page_control;
  logic [7:0]    fuse_load_control;
  logic [7:0]    host_interface_config;
  logic          lock_bit;
  logic          emu_active_q;
  logic [7:0]    addr_ptr;
  access_rsp_t   rsp_q;

  buck_setting_t next_setting_a;
  buck_setting_t next_setting_b;
  logic [7:0]    next_page_control;
  logic [7:0]    next_fuse_load_control;
  logic [7:0]    next_host_interface_config;
  logic          next_lock_bit;
  logic [7:0]    next_addr_ptr;
  access_rsp_t   next_rsp;
  logic          next_reload_start;

  // ----------------------------------------------------------------------
  // address mapping
  // ----------------------------------------------------------------------
  logic [7:0] cur_addr;
  logic [8:0] full_addr;
  logic       addr_ok;
  logic [2:0] page_sel;

  always_comb
  begin
    page_sel  = page_control[2:0];
    cur_addr  = req.first ? req.addr : addr_ptr;
    full_addr = 9'h000;
    addr_ok   = 1'b0;
    if (req.two_wire)
    begin
      // the upper address pair always lands in the upper block
      if (page_sel[1] || req.upper_pair)
      begin
        full_addr = {2'b10, cur_addr[6:0]};
        addr_ok   = !cur_addr[7] && !page_sel[2];
      end
      else
      begin
        full_addr = {1'b0, cur_addr};
        addr_ok   = !page_sel[2];
      end
    end
    else
    begin
      // only 7 address bits per four-wire frame, so three windows
      case (page_sel)
        PAGE_LOW_HALF:
        begin
          full_addr = {2'b00, cur_addr[6:0]};
          addr_ok   = 1'b1;
        end
        PAGE_HIGH_HALF:
        begin
          full_addr = {2'b01, cur_addr[6:0]};
          addr_ok   = 1'b1;
        end
        PAGE_UPPER:
        begin
          full_addr = {2'b10, cur_addr[6:0]};
          addr_ok   = 1'b1;
        end
        // production pages are left unmapped here
        default:
        begin
          full_addr = 9'h000;
          addr_ok   = 1'b0;
        end
      endcase
    end
  end

  // page control is mirrored at the first slot of every window,
  // otherwise a four-wire host stuck on page 0 could never leave it
  logic hit_page;
  logic hit_fuse;
  logic hit_iface;
  logic hit_set_a;
  logic hit_set_b;

  always_comb
  begin
    hit_page  = addr_ok && (full_addr[6:0] == OFF_PAGE_CONTROL[6:0]);
    hit_fuse  = addr_ok && (full_addr == OFF_FUSE_LOAD_CONTROL);
    hit_iface = addr_ok && (full_addr == OFF_HOST_INTERFACE_CONFIG);
    hit_set_a = addr_ok && (full_addr == OFF_BUCK_B_SETTING_A);
    hit_set_b = addr_ok && (full_addr == OFF_BUCK_B_SETTING_B);
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic wr;

  always_comb
  begin
    wr                         = req.valid && req.write;
    next_setting_a             = setting_a;
    next_setting_b             = setting_b;
    next_page_control          = page_control;
    next_fuse_load_control     = fuse_load_control;
    next_host_interface_config = host_interface_config;
    next_lock_bit              = lock_bit;
    next_addr_ptr              = addr_ptr;
    next_reload_start          = 1'b0;
    next_rsp                   = '0;

    // clear of load done on leaving emulated read; a write of 1 wins
    if (emu_active_q && !emulated_read_active)
      next_fuse_load_control[BIT_EMU_LOAD_DONE] = 1'b0;

    // fuse loader answer: interface word and lock come back
    if (fuse_reload_done && fuse_load_control[BIT_APP_RELOAD])
    begin
      next_fuse_load_control[BIT_APP_RELOAD] = 1'b0;
      next_host_interface_config             = fuse_interface_value;
      next_lock_bit                          = fuse_lock_value;
    end

    // page_auto_return after the access closes, before any new write below
    if (access_end && page_control[BIT_PAGE_AUTO_RETURN])
      next_page_control[2:0] = PAGE_LOW_HALF;

    if (req.valid)
    begin
      next_rsp.ack    = 1'b1;
      next_rsp.mapped = hit_page | hit_fuse | hit_iface
                      | hit_set_a | hit_set_b;
      // repeated write keeps hammering one register
      if (wr && req.two_wire && page_control[BIT_WRITE_REPEAT])
        next_addr_ptr = cur_addr;
      else
        next_addr_ptr = cur_addr + 8'h01;
      unique case (1'b1)
        hit_page:  next_rsp.rdata = page_control;
        hit_fuse:  next_rsp.rdata = fuse_load_control;
        hit_iface: next_rsp.rdata = host_interface_config;
        hit_set_a: next_rsp.rdata = setting_a;
        hit_set_b: next_rsp.rdata = setting_b;
        default:   next_rsp.rdata = 8'h00;
      endcase
    end

    if (wr)
    begin
      if (hit_page)
        next_page_control = req.wdata & MASK_PAGE_CONTROL;
      if (hit_fuse)
      begin
        next_fuse_load_control = req.wdata & MASK_FUSE_LOAD_CONTROL;
        if (req.wdata[BIT_APP_RELOAD])
          next_reload_start = 1'b1;
      end
      if (hit_iface)
        next_host_interface_config = req.wdata & MASK_HOST_INTERFACE;
      if (hit_set_a)
        next_setting_a = req.wdata;
      if (hit_set_b)
        next_setting_b = req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setting_a             <= RST_BUCK_B_SETTING;
      setting_b             <= RST_BUCK_B_SETTING;
      page_control          <= RST_PAGE_CONTROL;
      fuse_load_control     <= RST_FUSE_LOAD;
      host_interface_config <= RST_HOST_INTERFACE;
      lock_bit              <= 1'b0;
      emu_active_q          <= 1'b0;
      addr_ptr              <= 8'h00;
      rsp_q                 <= '0;
      fuse_reload_start     <= 1'b0;
    end
    else
    begin
      setting_a             <= next_setting_a;
      setting_b             <= next_setting_b;
      page_control          <= next_page_control;
      fuse_load_control     <= next_fuse_load_control;
      host_interface_config <= next_host_interface_config;
      lock_bit              <= next_lock_bit;
      emu_active_q          <= emulated_read_active;
      addr_ptr              <= next_addr_ptr;
      rsp_q                 <= next_rsp;
      fuse_reload_start     <= next_reload_start;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic [3:0]    base_nibble;
  buck_setting_t chosen;

  always_comb
  begin
    base_nibble = host_interface_config[7:4];
    if (base_nibble == NIBBLE_UNPROGRAMMED)
      base_nibble = DEFAULT_BASE_NIBBLE;
    chosen = sel_sync ? setting_b : setting_a;
  end

  assign rsp                 = rsp_q;
  assign active_base_nibble  = base_nibble;
  assign active_setting      = chosen;
  // 300 mV at code zero, 10 mV per step
  assign active_millivolts   = VOLT_BASE_MV
                             + 11'(chosen.code * VOLT_STEP_MV);
  assign fuse_marginal_read  = fuse_load_control[BIT_FUSE_TIMING];
  assign app_settings_lock   = lock_bit;
  // low three bits: 0 + pair bit + direction bit
  assign two_wire_addr_match = (two_wire_addr[6:3] == base_nibble)
                             && (two_wire_addr[2] == 1'b0);
  assign two_wire_addr_upper = two_wire_addr[1];
  assign two_wire_addr_read  = two_wire_addr[0];
  assign four_wire_is_read   = (four_wire_dir_bit
    == host_interface_config[BIT_DIR_POLARITY]);

endmodule : register_page_and_interface_config
`default_nettype wire

// ---- hdl/regpage_pkg.sv ----
package regpage_pkg;

  // ----------------------------------------------------------------------
  // register offsets (full nine-bit register address)
  // ----------------------------------------------------------------------
  localparam logic [8:0] OFF_BUCK_B_SETTING_A     = 9'h0D9;
  localparam logic [8:0] OFF_BUCK_B_SETTING_B     = 9'h0DA;
  localparam logic [8:0] OFF_PAGE_CONTROL         = 9'h100;
  localparam logic [8:0] OFF_FUSE_LOAD_CONTROL    = 9'h101;
  localparam logic [8:0] OFF_HOST_INTERFACE_CONFIG = 9'h105;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_MODE_SEL         = 7;
  localparam int BIT_PAGE_AUTO_RETURN = 7;
  localparam int BIT_WRITE_REPEAT     = 6;
  localparam int BIT_EMU_LOAD_DONE    = 3;
  localparam int BIT_APP_RELOAD       = 2;
  localparam int BIT_FUSE_TIMING      = 0;
  localparam int BIT_DIR_POLARITY     = 3;

  // writable masks, reserved bits read zero
  localparam logic [7:0] MASK_PAGE_CONTROL      = 8'hC7;
  localparam logic [7:0] MASK_FUSE_LOAD_CONTROL = 8'h0D;
  localparam logic [7:0] MASK_HOST_INTERFACE    = 8'hFF;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BUCK_B_SETTING = 8'h00;
  localparam logic [7:0] RST_PAGE_CONTROL   = 8'h00;
  localparam logic [7:0] RST_FUSE_LOAD      = 8'h00;
  localparam logic [7:0] RST_HOST_INTERFACE = 8'h00;

  // ----------------------------------------------------------------------
  // page codes and address decode
  // ----------------------------------------------------------------------
  localparam logic [2:0] PAGE_LOW_HALF  = 3'h0;
  localparam logic [2:0] PAGE_HIGH_HALF = 3'h1;
  localparam logic [2:0] PAGE_UPPER     = 3'h2;
  localparam logic [3:0] NIBBLE_UNPROGRAMMED = 4'h0;

  // ----------------------------------------------------------------------
  // voltage code scale
  // ----------------------------------------------------------------------
  localparam logic [10:0] VOLT_BASE_MV = 11'h12C;
  localparam logic [3:0]  VOLT_STEP_MV = 4'hA;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       first;
    logic       two_wire;
    logic       upper_pair;
    logic [7:0] addr;
    logic [7:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic       ack;
    logic       mapped;
    logic [7:0] rdata;
  } access_rsp_t;

  typedef struct packed {
    logic       auto_mode;
    logic [6:0] code;
  } buck_setting_t;

endpackage : regpage_pkg

// ---- sim/regpage_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module regpage_checker
(
  input wire logic                       clock,
  input wire logic                       rst_n,
  input wire regpage_pkg::access_req_t   req,
  input wire logic                       fuse_reload_done,
  input wire logic [6:0]                 two_wire_addr,
  input wire regpage_pkg::access_rsp_t   rsp,
  input wire logic                       two_wire_addr_match,
  input wire logic                       two_wire_addr_upper,
  input wire logic                       two_wire_addr_read,
  input wire logic [3:0]                 active_base_nibble,
  input wire regpage_pkg::buck_setting_t active_setting,
  input wire logic [10:0]                active_millivolts,
  input wire logic                       fuse_reload_start,
  input wire logic                       app_settings_lock
);
  import regpage_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_ack; req.valid |=> rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_idle; !req.valid |=> !rsp.ack; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_unm; rsp.ack && !rsp.mapped |-> rsp.rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_mv;
    active_millivolts == 11'h12C + 11'hA * 11'(active_setting.code);
  endproperty
  a_mv: assert property (p_mv) else $error("bad millivolts");
  property p_match;
    two_wire_addr_match == (two_wire_addr[6:3] == active_base_nibble
                            && !two_wire_addr[2]);
  endproperty
  a_match: assert property (p_match) else $error("bad match");
  property p_pair;
    {two_wire_addr_upper, two_wire_addr_read} == two_wire_addr[1:0];
  endproperty
  a_pair: assert property (p_pair) else $error("bad pair");
  property p_dflt; active_base_nibble != 4'h0; endproperty
  a_dflt: assert property (p_dflt) else $error("nibble zero");
  property p_pulse; fuse_reload_start |=> !fuse_reload_start; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_lock;
    $changed(app_settings_lock) |-> $past(fuse_reload_done);
  endproperty
  a_lock: assert property (p_lock) else $error("lock moved");

  c_map: cover property (rsp.ack && rsp.mapped);
  c_unm: cover property (rsp.ack && !rsp.mapped);
  c_rel: cover property (fuse_reload_start);
endmodule : regpage_checker

bind register_page_and_interface_config regpage_checker u_chk
(
  .clock               (clock),
  .rst_n               (rst_n),
  .req                 (req),
  .fuse_reload_done    (fuse_reload_done),
  .two_wire_addr       (two_wire_addr),
  .rsp                 (rsp),
  .two_wire_addr_match (two_wire_addr_match),
  .two_wire_addr_upper (two_wire_addr_upper),
  .two_wire_addr_read  (two_wire_addr_read),
  .active_base_nibble  (active_base_nibble),
  .active_setting      (active_setting),
  .active_millivolts   (active_millivolts),
  .fuse_reload_start   (fuse_reload_start),
  .app_settings_lock   (app_settings_lock)
);
`default_nettype wire

// ---- sim/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// protocol engine model
// ------------------------------------------------------------
module host_model
(
  input  wire logic                    clock,
  input  wire regpage_pkg::access_rsp_t rsp,
  output regpage_pkg::access_req_t      req,
  output logic                          access_end
);
  import regpage_pkg::*;
  initial req = '0;
  initial access_end = 1'b0;

  // page codes above 010 are never sent by this host
  // released fields go inverted so stale bytes cannot pass as held
  task automatic xfer(input logic w, f, tw, up, input logic [7:0] a, d,
                      output logic [7:0] rd, output logic mp);
    @(negedge clock);
    req <= '{1'b1, w, f, tw, up, a, d};
    @(negedge clock);
    // the answer stands for one cycle only, so take it while it stands
    req <= '{1'b0, ~w, ~f, ~tw, ~up, ~a, ~d};
    rd = rsp.rdata;
    mp = rsp.mapped;
  endtask : xfer

  task automatic finish_access();
    @(negedge clock);
    access_end <= 1'b1;
    @(negedge clock);
    access_end <= 1'b0;
  endtask : finish_access
endmodule : host_model
`default_nettype wire

// ---- sim/register_page_and_interface_config_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module register_page_and_interface_config_tb;
  import regpage_pkg::*;
  logic          clock, rst_n, access_end, dir, pin_b, emu, rl_done, lk;
  logic [6:0]    tw_addr;
  logic [7:0]    fuse_if, rdv;
  logic          mpv, match, upper, rdf, is_rd, start, marg, lock;
  logic [3:0]    nib;
  logic [10:0]   mv;
  access_req_t   req;
  access_rsp_t   rsp;
  buck_setting_t setting;
  int            num_errors, tests_run, cycles, n_starts;

  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  always #2.5 clock = ~clock;
  host_model host (.clock(clock), .rsp(rsp), .req(req),
                   .access_end(access_end));
  register_page_and_interface_config dut (
    .clock(clock), .rst_n(rst_n), .req(req), .access_end(access_end),
    .two_wire_addr(tw_addr), .four_wire_dir_bit(dir),
    .setting_b_select_pin(pin_b), .emulated_read_active(emu),
    .fuse_reload_done(rl_done), .fuse_interface_value(fuse_if),
    .fuse_lock_value(lk), .rsp(rsp), .two_wire_addr_match(match),
    .two_wire_addr_upper(upper), .two_wire_addr_read(rdf),
    .four_wire_is_read(is_rd), .active_base_nibble(nib),
    .active_setting(setting), .active_millivolts(mv),
    .fuse_reload_start(start), .fuse_marginal_read(marg),
    .app_settings_lock(lock));

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (start === 1'b1)
      n_starts++;
    if (cycles == 4000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [10:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic tw, up, input logic [7:0] a, d);
    host.xfer(1'b1, 1'b1, tw, up, a, d, rdv, mpv);
  endtask : wr

  task automatic rdc(input string n, input logic tw, up,
                     input logic [7:0] a, e);
    host.xfer(1'b0, 1'b1, tw, up, a, 8'h00, rdv, mpv);
    chk(n, 11'(e), 11'(rdv));
  endtask : rdc

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc("page_rst", 1'b0, 1'b0, 8'h00, 8'h00);
    chk("nib_rst", 11'hD, 11'(nib));
  endtask : t_reset

  task automatic t_settings();
    wr(1'b0, 1'b0, 8'h00, 8'h01);
    wr(1'b0, 1'b0, 8'h59, 8'h85);
    wr(1'b0, 1'b0, 8'h5A, 8'h7F);
    rdc("set_b_rd", 1'b0, 1'b0, 8'h5A, 8'h7F);
    repeat (4) @(negedge clock);
    chk("set_a", 11'h085, 11'(setting));
    chk("mv_a", 11'h15E, mv);
    pin_b = 1'b1;
    repeat (4) @(negedge clock);
    chk("set_b", 11'h07F, 11'(setting));
    chk("mv_b", 11'h622, mv);
    wr(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : t_settings

  task automatic t_page_auto_return();
    wr(1'b0, 1'b0, 8'h00, 8'h82);
    wr(1'b0, 1'b0, 8'h05, 8'hE8);
    host.finish_access();
    rdc("page_auto_return", 1'b0, 1'b0, 8'h00, 8'h80);
    chk("nib_set", 11'hE, 11'(nib));
    dir = 1'b1;
    @(negedge clock);
    chk("pol_one", 11'h1, 11'(is_rd));
    dir = 1'b0;
    @(negedge clock);
    chk("pol_one_wr", 11'h0, 11'(is_rd));
    wr(1'b0, 1'b0, 8'h00, 8'h02);
    wr(1'b0, 1'b0, 8'h05, 8'h00);
    wr(1'b0, 1'b0, 8'h00, 8'h00);
    chk("nib_dflt", 11'hD, 11'(nib));
    dir = 1'b0;
    @(negedge clock);
    chk("pol_zero", 11'h1, 11'(is_rd));
  endtask : t_page_auto_return

  task automatic t_two_wire();
    tw_addr = 7'b1101011;
    @(negedge clock);
    chk("addr_d3", 11'h7, 11'({match, upper, rdf}));
    tw_addr = 7'b1110000;
    @(negedge clock);
    chk("addr_e0", 11'h0, 11'({match, upper, rdf}));
    wr(1'b1, 1'b1, 8'h01, 8'hF3);
    rdc("fuse_rsv", 1'b1, 1'b1, 8'h01, 8'h01);
    chk("marginal", 11'h1, 11'(marg));
    rdc("tw_low", 1'b1, 1'b0, 8'hDA, 8'h7F);
    host.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h80, 8'h00, rdv, mpv);
    chk("unmapped", 11'h0, 11'({mpv, rdv}));
    wr(1'b1, 1'b0, 8'h00, 8'h40);
    wr(1'b1, 1'b0, 8'hD9, 8'h11);
    host.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h22, rdv, mpv);
    rdc("rep_a", 1'b1, 1'b0, 8'hD9, 8'h22);
    rdc("rep_b", 1'b1, 1'b0, 8'hDA, 8'h7F);
    wr(1'b1, 1'b0, 8'h00, 8'h00);
    wr(1'b1, 1'b0, 8'hD9, 8'h33);
    host.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h44, rdv, mpv);
    rdc("pgw_b", 1'b1, 1'b0, 8'hDA, 8'h44);
  endtask : t_two_wire

  task automatic t_fuse();
    emu = 1'b1;
    n_starts = 0;
    wr(1'b1, 1'b1, 8'h01, 8'h0C);
    repeat (2) @(negedge clock);
    chk("start", 11'h1, 11'(n_starts));
    chk("marg_off", 11'h0, 11'(marg));
    fuse_if = 8'hA8;
    lk = 1'b1;
    rl_done = 1'b1;
    @(negedge clock);
    rl_done = 1'b0;
    @(negedge clock);
    chk("lock", 11'h1, 11'(lock));
    chk("nib_fuse", 11'hA, 11'(nib));
    rdc("ctl_done", 1'b1, 1'b1, 8'h01, 8'h08);
    emu = 1'b0;
    repeat (2) @(negedge clock);
    rdc("ctl_clr", 1'b1, 1'b1, 8'h01, 8'h00);
  endtask : t_fuse

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    {dir, pin_b, emu, rl_done, lk} = 5'h00;
    tw_addr = 7'h00;
    fuse_if = 8'h00;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_reset();
    t_settings();
    t_page_auto_return();
    t_two_wire();
    t_fuse();
    stop_test();
  end
endmodule : register_page_and_interface_config_tb
`default_nettype wire
